// ==== logic/sfw_pkg.sv ====
/*
  Shared constants, types and field layouts for the serial flash
  program / erase / burst-wrap sequencer.
  Assumes a 200 MHz core clock and a host-driven serial clock.
*/
package sfw_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] OP_WRAP_SET = 8'h77;
  localparam logic [7:0] OP_READ_PARAM = 8'hc0;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PROG4 = 8'h12;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_QPROG4 = 8'h34;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;

  //////////////////////////////////////////////////////////////////////////////
  // frame lengths in bits
  localparam logic [3:0] OPCODE_BITS = 4'h8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [5:0] PARAM_BITS = 6'h08;

  //////////////////////////////////////////////////////////////////////////////
  // wrap-setting byte fields and reset values
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_LEN_LSB = 5;
  localparam int RDPAR_LEN_LSB = 0;
  localparam logic WRAP_DIS_RESET = 1'b1;
  localparam logic [1:0] WRAP_LEN_RESET = 2'h0;
  localparam logic [7:0] WRAP_MIN_BYTES = 8'h08;

  //////////////////////////////////////////////////////////////////////////////
  // array geometry
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int PAGE_BITS = 8;
  localparam int SECTOR_BITS = 12;

  //////////////////////////////////////////////////////////////////////////////
  // self-timed durations (values arbitrary, no figures given)
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_TIME_NS = 700000;
  localparam int ERASE_TIME_NS = 45000000;
  localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CHECK = 5'h02,
    ST_PROG = 5'h04,
    ST_ERASE = 5'h08,
    ST_WAIT = 5'h10
  } sfw_state_t;

  typedef enum logic [2:0] {
    CK_NONE = 3'h0,
    CK_WRAP = 3'h1,
    CK_RDPAR = 3'h2,
    CK_PROG = 3'h3,
    CK_ERASE = 3'h4,
    CK_WREN = 3'h5,
    CK_WRDI = 3'h6
  } sfw_kind_t;

  typedef struct packed {
    logic wrap_disable_bit;
    logic [1:0] wrap_length_sel;
  } sfw_wrap_t;

  typedef struct packed {
    sfw_kind_t kind;
    logic quad;
    logic complete;
    logic [31:0] addr;
    logic [7:0] param;
  } sfw_frame_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [7:0] wdata;
  } sfw_mem_t;

endpackage

// ==== logic/sfw_core.sv ====
/*
  Serial flash command sequencer: burst-wrap setting, page program and
  sector erase, with a self-timed busy phase and an external byte array.
  Assumes a host that frames commands with i_cs_n and i_sclk, an array with
  one-cycle read latency on i_clock, and protection logic answering
  i_prot_hit combinationally from o_prot_addr.
*/
`timescale 1ns/1ps
module sfw_core
  import sfw_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF,
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
) (
  // core clock and control
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_soft_reset,
  // serial link from the host
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  // modes and protection
  input wire logic i_four_wire_command_mode,
  input wire logic i_addr4_mode,
  input wire logic i_quad_enable_bit,
  input wire logic i_prot_hit,
  output logic [31:0] o_prot_addr,
  // status
  output logic o_busy,
  output logic o_write_enable_latch,
  output sfw_wrap_t o_wrap_setting,
  // byte array
  output sfw_mem_t o_mem,
  input wire logic [7:0] i_mem_rdata,
  // read address sequencing
  input wire logic i_rd_load,
  input wire logic [31:0] i_rd_addr,
  input wire logic i_rd_step,
  input wire logic i_rd_wrap_read,
  input wire logic i_rd_burst_wrap,
  output logic [31:0] o_rd_addr
);

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] shift_in(input logic [31:0] sr, input logic [3:0] nib,
                                           input logic four);
    shift_in = four ? {sr[27:0], nib} : {sr[30:0], nib[0]};
  endfunction

  function automatic sfw_kind_t frame_kind(input logic [7:0] op, input logic four_wire_command_mode);
    frame_kind = CK_NONE;
    if (op == OP_WRAP_SET && !four_wire_command_mode) frame_kind = CK_WRAP;
    else if (op == OP_READ_PARAM && four_wire_command_mode) frame_kind = CK_RDPAR;
    else if (op == OP_PROG) frame_kind = CK_PROG;
    else if ((op == OP_PROG4 || op == OP_QPROG || op == OP_QPROG4) && !four_wire_command_mode) frame_kind = CK_PROG;
    else if (op == OP_SECT_ERASE) frame_kind = CK_ERASE;
    else if (op == OP_WREN) frame_kind = CK_WREN;
    else if (op == OP_WRDI) frame_kind = CK_WRDI;
  endfunction

  function automatic logic [31:0] rd_next(input logic [31:0] a, input logic [1:0] len,
                                          input logic wrap);
    logic [31:0] mask;
    mask = 32'h0;
    mask[7:0] = (WRAP_MIN_BYTES << len) - 8'h01;
    rd_next = wrap ? ((a & ~mask) | ((a + 32'h1) & mask)) : a + 32'h1;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // link side, clocked by the host serial clock

  logic lk_first;
  logic [1:0] lk_mode_s1;
  logic [1:0] lk_mode_s2;
  logic lk_busy_s1;
  logic lk_busy_s2;
  logic [7:0] op_sr;
  logic [3:0] op_cnt;
  logic [5:0] head_cnt;
  logic [31:0] addr_sr;
  logic [7:0] byte_sr;
  logic [3:0] bit_cnt;
  logic [7:0] nbyte;
  logic has_data;
  logic [255:0] valid;
  logic [7:0] page_buf [0:255];

  wire lk_qpi = lk_mode_s2[1];
  wire lk_a4 = lk_mode_s2[0];
  wire [3:0] lanes_op = lk_qpi ? 4'h4 : 4'h1;
  wire op_done = (op_cnt == OPCODE_BITS);
  wire [31:0] op_first = shift_in(32'h0, i_io, lk_qpi);
  wire [31:0] op_shift = shift_in({24'h0, op_sr}, i_io, lk_qpi);
  wire sfw_kind_t op_kind = frame_kind(op_sr, lk_qpi);
  wire sfw_kind_t next_kind = frame_kind(op_shift[7:0], lk_qpi);
  wire op_quad = (op_sr == OP_QPROG) || (op_sr == OP_QPROG4);
  wire op_wide = lk_a4 || (op_sr == OP_PROG4) || (op_sr == OP_QPROG4);
  wire [5:0] addr_len = op_wide ? ADDR4_BITS : ADDR3_BITS;
  wire [5:0] dummy_len = lk_a4 ? ADDR4_BITS : ADDR3_BITS;
  wire [5:0] head_len = (op_kind == CK_PROG || op_kind == CK_ERASE) ? addr_len :
                        (op_kind == CK_WRAP) ? dummy_len + PARAM_BITS :
                        (op_kind == CK_RDPAR) ? PARAM_BITS : 6'h00;
  wire four_body = lk_qpi || op_quad;
  wire [3:0] lanes_body = four_body ? 4'h4 : 4'h1;
  wire [31:0] addr_shift = shift_in(addr_sr, i_io, four_body);
  wire [31:0] byte_shift = shift_in({24'h0, byte_sr}, i_io, four_body);
  wire [3:0] bit_sum = bit_cnt + lanes_body;
  wire in_head = op_done && (head_cnt != head_len);
  wire byte_end = op_done && !in_head && (bit_sum == BYTE_BITS);
  wire [7:0] wr_idx = addr_sr[7:0] + nbyte;
  wire buf_we = !lk_first && byte_end && (op_kind == CK_PROG) && !lk_busy_s2;
  wire valid_clr = !lk_first && !op_done && (op_cnt + lanes_op == OPCODE_BITS) &&
                   (next_kind == CK_PROG) && !lk_busy_s2;

  sfw_frame_t lk_frame;
  assign lk_frame.kind = op_done ? op_kind : CK_NONE;
  assign lk_frame.quad = op_quad;
  // select must rise right after a whole byte, with data only for program
  assign lk_frame.complete = op_done && !in_head && (bit_cnt == 4'h0) &&
                             ((op_kind == CK_PROG) ? has_data : !has_data);
  assign lk_frame.addr = addr_sr;
  assign lk_frame.param = addr_sr[7:0];

  // set while select is high so the next frame restarts its counters
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      lk_first <= 1'b1;
    end else begin
      lk_first <= 1'b0;
    end
  end

  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_mode_s1 <= 2'h0;
      lk_mode_s2 <= 2'h0;
      lk_busy_s1 <= 1'b0;
      lk_busy_s2 <= 1'b0;
    end else begin
      lk_mode_s1 <= {i_four_wire_command_mode, i_addr4_mode};
      lk_mode_s2 <= lk_mode_s1;
      lk_busy_s1 <= o_busy;
      lk_busy_s2 <= lk_busy_s1;
    end
  end

  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_sr <= 8'h00;
      op_cnt <= 4'h0;
      head_cnt <= 6'h00;
      addr_sr <= 32'h0;
      byte_sr <= 8'h00;
      bit_cnt <= 4'h0;
      nbyte <= 8'h00;
      has_data <= 1'b0;
    end else if (lk_first) begin
      op_sr <= op_first[7:0];
      op_cnt <= lanes_op;
      head_cnt <= 6'h00;
      addr_sr <= 32'h0;
      byte_sr <= 8'h00;
      bit_cnt <= 4'h0;
      nbyte <= 8'h00;
      has_data <= 1'b0;
    end else if (!op_done) begin
      op_sr <= op_shift[7:0];
      op_cnt <= op_cnt + lanes_op;
    end else if (in_head) begin
      addr_sr <= addr_shift;
      head_cnt <= head_cnt + {2'h0, lanes_body};
    end else begin
      byte_sr <= byte_shift[7:0];
      bit_cnt <= byte_end ? 4'h0 : bit_sum;
      if (byte_end) begin
        nbyte <= nbyte + 8'h01;
        has_data <= 1'b1;
      end
    end
  end

  // marks which page bytes this frame supplied; the rest are left alone
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      valid <= 256'h0;
    end else if (valid_clr) begin
      valid <= 256'h0;
    end else if (buf_we) begin
      valid[wr_idx] <= 1'b1;
    end
  end

  always_ff @(posedge i_sclk) begin
    if (buf_we) begin
      page_buf[wr_idx] <= byte_shift[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core side; link results are read only after select has risen and the
  // serial clock is idle, so they are stable when sampled

  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  sfw_state_t state;
  logic [1:0] ph;
  logic [12:0] idx;
  logic [31:0] timer;
  logic [31:0] cap_addr;
  logic cap_erase;
  sfw_wrap_t wrap;
  logic write_enable_latch;
  logic busy;
  sfw_mem_t mem;
  logic [31:0] rd_addr;

  wire cs_rise = cs_s2 && !cs_s3;
  wire take = cs_rise && (state == ST_IDLE);
  wire fr_ok = take && lk_frame.complete;
  wire wrap_take = fr_ok && (lk_frame.kind == CK_WRAP);
  wire rdpar_take = fr_ok && (lk_frame.kind == CK_RDPAR);
  wire wren_take = fr_ok && (lk_frame.kind == CK_WREN);
  wire wrdi_take = fr_ok && (lk_frame.kind == CK_WRDI);
  wire exec_ok = fr_ok && (lk_frame.kind == CK_PROG || lk_frame.kind == CK_ERASE) &&
                 write_enable_latch && (!lk_frame.quad || i_quad_enable_bit);
  wire cycle_end = (state == ST_WAIT) && (timer == 32'h0);
  wire [7:0] buf_byte = page_buf[idx[7:0]];
  wire rd_wrap_on = i_rd_burst_wrap || (i_rd_wrap_read && !wrap.wrap_disable_bit);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end else if (i_clk_en) begin
      cs_s1 <= i_cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  // the wrap command keeps only bits 6..4, dropping the top bit and low nibble; the read-parameter command keeps bits 1..0
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wrap.wrap_disable_bit <= WRAP_DIS_RESET;
      wrap.wrap_length_sel <= WRAP_LEN_RESET;
    end else if (i_clk_en) begin
      if (i_soft_reset) begin
        wrap.wrap_disable_bit <= WRAP_DIS_RESET;
      end else if (wrap_take) begin
        wrap.wrap_disable_bit <= lk_frame.param[WRAP_DIS_POS];
        wrap.wrap_length_sel <= lk_frame.param[WRAP_LEN_LSB +: 2];
      end else if (rdpar_take) begin
        wrap.wrap_length_sel <= lk_frame.param[RDPAR_LEN_LSB +: 2];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (i_clk_en) begin
      if (cycle_end) begin
        write_enable_latch <= 1'b0;
      end else if (wren_take) begin
        write_enable_latch <= 1'b1;
      end else if (wrdi_take) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_addr <= 32'h0;
    end else if (i_clk_en) begin
      if (i_rd_load) begin
        rd_addr <= i_rd_addr;
      end else if (i_rd_step) begin
        rd_addr <= rd_next(rd_addr, wrap.wrap_length_sel, rd_wrap_on);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      ph <= 2'h0;
      idx <= 13'h0;
      timer <= 32'h0;
      cap_addr <= 32'h0;
      cap_erase <= 1'b0;
      busy <= 1'b0;
      mem <= '0;
    end else if (i_clk_en) begin
      case (state)
        ST_IDLE: begin
          if (exec_ok) begin
            cap_addr <= lk_frame.addr;
            cap_erase <= (lk_frame.kind == CK_ERASE);
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          idx <= 13'h0;
          ph <= 2'h0;
          if (i_prot_hit) begin
            state <= ST_IDLE;
          end else begin
            busy <= 1'b1;
            state <= cap_erase ? ST_ERASE : ST_PROG;
          end
        end
        ST_PROG: begin
          case (ph)
            2'h0: begin
              if (idx[PAGE_BITS]) begin
                timer <= PROG_CYCLES - 1;
                state <= ST_WAIT;
              end else if (valid[idx[7:0]]) begin
                mem.rd <= 1'b1;
                mem.addr <= {cap_addr[31:PAGE_BITS], idx[7:0]};
                ph <= 2'h1;
              end else begin
                idx <= idx + 13'h1;
              end
            end
            2'h1: begin
              mem.rd <= 1'b0;
              ph <= 2'h2;
            end
            2'h2: begin
              mem.wr <= 1'b1;
              mem.wdata <= i_mem_rdata & buf_byte;
              ph <= 2'h3;
            end
            default: begin
              mem.wr <= 1'b0;
              idx <= idx + 13'h1;
              ph <= 2'h0;
            end
          endcase
        end
        ST_ERASE: begin
          if (idx[SECTOR_BITS]) begin
            mem.wr <= 1'b0;
            timer <= ERASE_CYCLES - 1;
            state <= ST_WAIT;
          end else begin
            mem.wr <= 1'b1;
            mem.addr <= {cap_addr[31:SECTOR_BITS], idx[11:0]};
            mem.wdata <= ERASED_BYTE;
            idx <= idx + 13'h1;
          end
        end
        ST_WAIT: begin
          if (timer == 32'h0) begin
            busy <= 1'b0;
            state <= ST_IDLE;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_busy = busy;
  assign o_write_enable_latch = write_enable_latch;
  assign o_wrap_setting = wrap;
  assign o_mem = mem;
  assign o_prot_addr = cap_addr;
  assign o_rd_addr = rd_addr;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_wrap_reset_default: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_clk_en && i_soft_reset |=> wrap.wrap_disable_bit)
    else $error("wrap not disabled after software reset");

  a_wrap_only_by_cmd: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !$stable(wrap) |-> $past(wrap_take) || $past(rdpar_take) || $past(i_soft_reset))
    else $error("wrap setting changed without a command");

  a_rd_wrap_bound: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_clk_en && i_rd_step && !i_rd_load && rd_wrap_on |=> o_rd_addr[31:6] == $past(rd_addr[31:6]))
    else $error("wrapped read left its section");

  a_rd_linear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_clk_en && i_rd_step && !i_rd_load && !rd_wrap_on |=> o_rd_addr == $past(rd_addr) + 32'h1)
    else $error("unwrapped read did not advance by one");

  a_busy_needs_wel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(o_busy) |-> o_write_enable_latch && $past(state == ST_CHECK, 1))
    else $error("busy started without write enable");

  a_wel_clear_end: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(o_busy) |-> !o_write_enable_latch && state == ST_IDLE)
    else $error("write enable latch not cleared at cycle end");

  a_prog_and_only: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_PROG && o_mem.wr |-> (o_mem.wdata & ~$past(i_mem_rdata)) == 8'h00)
    else $error("program would set a bit");

  a_erase_fill: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == ST_ERASE && o_mem.wr |->
      o_mem.wdata == ERASED_BYTE && o_mem.addr[31:12] == cap_addr[31:12])
    else $error("erase wrote outside its sector or not FFh");

  a_prot_refuse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_clk_en && state == ST_CHECK && i_prot_hit |=> state == ST_IDLE ##1 !o_busy)
    else $error("protected command was executed");

endmodule

// ==== sim/sfw_host_model.sv ====
/*
  Host side of the serial link: frames commands with select and clock.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module sfw_host_model (
  // serial link
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io
);
  localparam int HALF_NS = 24;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end
  // clock only runs inside frames
  task automatic clk_once(input logic [3:0] v);
    o_io = v;
    #HALF_NS o_sclk = 1'b1;
    #HALF_NS o_sclk = 1'b0;
  endtask
  task automatic open_frame();
    o_cs_n = 1'b0;
    #HALF_NS;
  endtask
  task automatic tx_byte(input logic [7:0] b, input logic quad);
    if (quad) begin
      clk_once(b[7:4]);
      clk_once(b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) clk_once({~o_io[3:1], b[i]});
    end
  endtask
  task automatic tx_addr(input logic [31:0] a, input logic four, input logic quad);
    if (four) tx_byte(a[31:24], quad);
    tx_byte(a[23:16], quad);
    tx_byte(a[15:8], quad);
    tx_byte(a[7:0], quad);
  endtask
  task automatic tx_bits(input int n);
    repeat (n) clk_once(4'hf);
  endtask
  // released lines flip so a stale value cannot pass as data
  task automatic close_frame();
    #HALF_NS o_cs_n = 1'b1;
    o_io = ~o_io;
    #(8 * HALF_NS);
  endtask
endmodule

// ==== sim/tb_top.sv ====
/*
  Self-checking bench for sfw_core: wrap setting, read wrap, program, erase.
  Assumes sfw_host_model on the link and a sparse byte array modelled here.
*/
`timescale 1ns/1ps
module tb_top;
  import sfw_pkg::*;
  logic clock, rst_n, soft_reset, sclk, cs_n, four_wire, addr4, quad_en, prot_hit;
  logic rd_load, rd_step, rd_wrap, busy, write_enable_latch, clk_en, burst_wrap;
  logic [3:0] io;
  logic [7:0] mem_rdata;
  logic [23:0] prot_page;
  logic [31:0] prot_addr, rd_start, rd_addr;
  sfw_wrap_t wrap;
  sfw_mem_t mem_if;
  logic [7:0] mem [logic [31:0]];
  int num_errors, num_checks, cycles;
  assign prot_hit = (prot_addr[31:8] == prot_page);
  sfw_host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(io));
  sfw_core #(.PROG_CYCLES(20), .ERASE_CYCLES(30)) i_dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_soft_reset(soft_reset),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io), .i_four_wire_command_mode(four_wire),
    .i_addr4_mode(addr4), .i_quad_enable_bit(quad_en), .i_prot_hit(prot_hit),
    .o_prot_addr(prot_addr), .o_busy(busy), .o_write_enable_latch(write_enable_latch),
    .o_wrap_setting(wrap), .o_mem(mem_if), .i_mem_rdata(mem_rdata),
    .i_rd_load(rd_load), .i_rd_addr(rd_start), .i_rd_step(rd_step),
    .i_rd_wrap_read(rd_wrap), .i_rd_burst_wrap(burst_wrap), .o_rd_addr(rd_addr));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  function automatic logic [7:0] rdm(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : ERASED_BYTE;
  endfunction
  always @(posedge clock) begin
    if (mem_if.wr) mem[mem_if.addr] = mem_if.wdata;
    if (mem_if.rd) mem_rdata <= rdm(mem_if.addr);
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      num_errors++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic cmd1(input logic [7:0] op);
    i_host.open_frame();
    i_host.tx_byte(op, 1'b0);
    i_host.close_frame();
  endtask
  // a short junk frame lets the link side pick up new mode levels
  task automatic sync_modes();
    i_host.open_frame();
    i_host.tx_bits(4);
    i_host.close_frame();
  endtask
  task automatic wrap_cmd(input logic [7:0] w, input logic four, input logic q);
    i_host.open_frame();
    i_host.tx_byte(OP_WRAP_SET, q);
    i_host.tx_addr(32'h0, four, q);
    i_host.tx_byte(w, q);
    i_host.close_frame();
  endtask
  task automatic prog(input logic [7:0] op, input logic q, input logic four,
                      input logic [31:0] a, input int n, input logic [7:0] d);
    i_host.open_frame();
    i_host.tx_byte(op, 1'b0);
    i_host.tx_addr(a, four, q);
    for (int i = 0; i < n; i++) i_host.tx_byte(d + 8'(i), q);
    i_host.close_frame();
  endtask
  task automatic erase(input logic [31:0] a);
    i_host.open_frame();
    i_host.tx_byte(OP_SECT_ERASE, 1'b0);
    i_host.tx_addr(a, 1'b0, 1'b0);
    i_host.close_frame();
  endtask
  task automatic run(input logic go);
    int k;
    chk("busy", {31'h0, go}, {31'h0, busy});
    for (k = 0; k < 6000 && busy !== 1'b0; k++) tick();
    chk("busy end", 32'h0, {31'h0, busy});
    if (go) chk("wel after", 32'h0, {31'h0, write_enable_latch});
  endtask
  task automatic rd_do(input logic ld, input logic [31:0] a, input logic [31:0] exp);
    tick();
    rd_load = ld;
    rd_start = a;
    rd_step = ~ld;
    tick();
    rd_load = 1'b0;
    rd_step = 1'b0;
    repeat (2) tick();
    chk("read address", exp, rd_addr);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_wrap();
    chk("wrap reset", 32'h4, {29'h0, wrap});
    for (int n = 0; n < 4; n++) begin
      wrap_cmd({1'b1, 2'(n), 1'b0, 4'hf}, 1'b0, 1'b0);
      chk("wrap len", 32'(n), {29'h0, wrap});
    end
    wrap_cmd(8'h10, 1'b0, 1'b0);
    chk("wrap off", 32'h4, {29'h0, wrap});
    wrap_cmd(8'h20, 1'b0, 1'b0);
    rd_do(1'b1, 32'h1e, 32'h1e);
    rd_do(1'b0, 32'h0, 32'h1f);
    rd_do(1'b0, 32'h0, 32'h10);
    tick();
    soft_reset = 1'b1;
    tick();
    soft_reset = 1'b0;
    tick();
    chk("wrap soft", 32'h5, {29'h0, wrap});
    rd_do(1'b1, 32'h1f, 32'h1f);
    rd_do(1'b0, 32'h0, 32'h20);
  endtask
  task automatic t_modes();
    tick();
    addr4 = 1'b1;
    sync_modes();
    wrap_cmd(8'h40, 1'b1, 1'b0);
    chk("wrap a4", 32'h2, {29'h0, wrap});
    wrap_cmd(8'h60, 1'b0, 1'b0);
    chk("wrap a4 short", 32'h2, {29'h0, wrap});
    tick();
    addr4 = 1'b0;
    four_wire = 1'b1;
    sync_modes();
    wrap_cmd(8'h70, 1'b0, 1'b1);
    chk("wrap quad", 32'h2, {29'h0, wrap});
    i_host.open_frame();
    i_host.tx_byte(OP_READ_PARAM, 1'b1);
    i_host.tx_byte(8'h03, 1'b1);
    i_host.close_frame();
    chk("wrap param", 32'h3, {29'h0, wrap});
    tick();
    four_wire = 1'b0;
    sync_modes();
  endtask
  task automatic t_prog();
    mem[32'h00010000] = 8'hf0;
    prog(OP_PROG, 1'b0, 1'b0, 32'h000100fe, 3, 8'h3c);
    run(1'b0);
    chk("mem kept", 32'hf0, {24'h0, rdm(32'h00010000)});
    cmd1(OP_WREN);
    chk("wel", 32'h1, {31'h0, write_enable_latch});
    prog(OP_PROG, 1'b0, 1'b0, 32'h000100fe, 3, 8'h3c);
    run(1'b1);
    chk("mem fe", 32'h3c, {24'h0, rdm(32'h000100fe)});
    chk("mem ff", 32'h3d, {24'h0, rdm(32'h000100ff)});
    chk("mem 00", 32'h30, {24'h0, rdm(32'h00010000)});
    cmd1(OP_WREN);
    i_host.open_frame();
    i_host.tx_byte(OP_PROG, 1'b0);
    i_host.tx_addr(32'h200, 1'b0, 1'b0);
    i_host.tx_byte(8'h00, 1'b0);
    i_host.tx_bits(3);
    i_host.close_frame();
    run(1'b0);
    tick();
    prot_page = 24'h000200;
    prog(OP_PROG, 1'b0, 1'b0, 32'h00020010, 1, 8'h00);
    run(1'b0);
    erase(32'h00020000);
    run(1'b0);
    chk("wel kept", 32'h1, {31'h0, write_enable_latch});
    tick();
    prot_page = 24'hffffff;
    prog(OP_PROG4, 1'b0, 1'b1, 32'h01000010, 1, 8'h5a);
    run(1'b1);
    chk("mem 4b", 32'h5a, {24'h0, rdm(32'h01000010)});
  endtask
  task automatic t_quad_erase();
    cmd1(OP_WREN);
    prog(OP_QPROG, 1'b1, 1'b0, 32'h300, 1, 8'h81);
    run(1'b0);
    tick();
    quad_en = 1'b1;
    prog(OP_QPROG, 1'b1, 1'b0, 32'h300, 1, 8'h81);
    run(1'b1);
    chk("mem quad", 32'h81, {24'h0, rdm(32'h300)});
    cmd1(OP_WREN);
    prog(OP_QPROG4, 1'b1, 1'b1, 32'h02000400, 1, 8'h42);
    run(1'b1);
    chk("mem quad4", 32'h42, {24'h0, rdm(32'h02000400)});
    mem[32'h5000] = 8'h11;
    mem[32'h5fff] = 8'h00;
    mem[32'h6000] = 8'h22;
    cmd1(OP_WREN);
    erase(32'h00005123);
    run(1'b1);
    chk("erase lo", 32'hff, {24'h0, rdm(32'h5000)});
    chk("erase hi", 32'hff, {24'h0, rdm(32'h5fff)});
    chk("erase next", 32'h22, {24'h0, rdm(32'h6000)});
  endtask
  // burst wrap, clock-enable freeze, write disable and a hard reset while idle
  task automatic t_extra();
    rd_wrap = 1'b0;
    burst_wrap = 1'b1;
    rd_do(1'b1, 32'h7f, 32'h7f);
    rd_do(1'b0, 32'h0, 32'h40);
    burst_wrap = 1'b0;
    rd_do(1'b0, 32'h0, 32'h41);
    rd_wrap = 1'b1;
    tick();
    clk_en = 1'b0;
    rd_step = 1'b1;
    repeat (3) tick();
    rd_step = 1'b0;
    clk_en = 1'b1;
    chk("read frozen", 32'h41, rd_addr);
    cmd1(OP_WREN);
    cmd1(OP_WRDI);
    chk("wel off", 32'h0, {31'h0, write_enable_latch});
    mem[32'h7010] = 8'h00;
    erase(32'h00007000);
    run(1'b0);
    chk("erase no wel", 32'h0, {24'h0, rdm(32'h7010)});
    tick();
    rst_n = 1'b0;
    repeat (2) tick();
    chk("wrap hard", 32'h4, {29'h0, wrap});
    rst_n = 1'b1;
    wrap_cmd(8'h00, 1'b0, 1'b0);
    chk("wrap after reset", 32'h0, {29'h0, wrap});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    soft_reset = 1'b0;
    four_wire = 1'b0;
    addr4 = 1'b0;
    quad_en = 1'b0;
    rd_load = 1'b0;
    rd_step = 1'b0;
    rd_wrap = 1'b1;
    clk_en = 1'b1;
    burst_wrap = 1'b0;
    rd_start = 32'h0;
    mem_rdata = 8'h0;
    prot_page = 24'hffffff;
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    t_wrap();
    t_modes();
    t_prog();
    t_quad_erase();
    t_extra();
    end_sim();
  end
endmodule
